/* File: design/rbf_flow_ctrl.v */
// Rotary buffer request flow control for several coordinate systems.
// Assumes a plain register port on ref_clk_in; panel select pins are async.
//
// Behaviour
// (R1) Count below on-point raises request line and clears full flag.
// (R2) Full flag of each system readable in status word at bit 11.
// (R3) Host learns readiness by interrupt from request line or polling.
// (R4) Line follows panel-selected system, or host system when panel disabled.
// (R5) Host should disable panel inputs so line follows its system.
// (R6) Hysteresis: full at off-point, cleared only below on-point.
// (R7) Every line write to the selected system drops request low at least one cycle.
// (R8) Count at or above off-point after write keeps line low, sets full.
// (R9) Per-system count of queued lines, up on write, down on execute.
`timescale 1ns/1ns
`default_nettype none
`include "rbf_map.vh"
module rbf_flow_ctrl #(
	parameter NSYS  = 8,
	parameter SYS_W = 3,
	parameter CNT_W = 24
) (
	// Clock and reset
	input  wire                   ref_clk_in,
	input  wire                   rst_n_in,
	// Register port
	input  wire [`RBF_ADDR_W-1:0] reg_addr_in,
	input  wire [`RBF_DATA_W-1:0] reg_wdata_in,
	input  wire                   reg_wr_in,
	input  wire                   reg_rd_in,
	output reg  [`RBF_DATA_W-1:0] reg_rdata_out,
	// Line events per coordinate system
	input  wire [NSYS-1:0]        line_write_in,
	input  wire [NSYS-1:0]        line_exec_in,
	// Panel pins
	input  wire [SYS_W-1:0]       panel_system_select_in,
	// Host side
	output reg                    buffer_request_line_out,
	output reg                    irq_out
);
	reg  [SYS_W-1:0]  pan_meta_r;
	reg  [SYS_W-1:0]  pan_sync_r;
	reg               panel_input_disable_r;
	reg  [CNT_W-1:0]  refill_on_threshold_r;
	reg  [CNT_W-1:0]  full_off_threshold_r;
	reg  [SYS_W-1:0]  host_sys_r;
	reg  [1:0]        int_stat_r;
	reg  [1:0]        int_mask_r;
	reg               req_prev_r;
	reg               full_prev_r;
	wire [NSYS*CNT_W-1:0] cnt_all;
	wire [NSYS-1:0]   full_all;
	wire [NSYS-1:0]   wseen_all;
	reg  [SYS_W-1:0]  sel_sys;
	reg               sel_full;
	reg               sel_wr;
	reg               req_nxt;
	reg  [1:0]        int_set;
	reg  [`RBF_DATA_W-1:0] rdata_nxt;

	// Out-of-range system indices read as idle rather than unknown, in
	// case NSYS is set below what SYS_W can address
	function rbf_bit_of;
		input [NSYS-1:0]  vec;
		input [SYS_W-1:0] idx;
		begin
			if (idx < NSYS)
				rbf_bit_of = vec[idx];
			else
				rbf_bit_of = 1'b0;
		end
	endfunction

	// Thresholds and counts sit in the low bits of a read word
	function [`RBF_DATA_W-1:0] rbf_word_of;
		input [CNT_W-1:0] val;
		begin
			rbf_word_of = {`RBF_DATA_W{1'b0}};
			rbf_word_of[CNT_W-1:0] = val;
		end
	endfunction

	// Queued count of one system out of the packed per-system vector
	function [CNT_W-1:0] rbf_count_of;
		input [NSYS*CNT_W-1:0] all;
		input [SYS_W-1:0]      idx;
		begin
			rbf_count_of = {CNT_W{1'b0}};
			if (idx < NSYS)
				rbf_count_of = all[idx*CNT_W +: CNT_W];
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NSYS; g = g + 1)
		begin : g_sys
			rbf_sys_flow #(
				.CNT_W (CNT_W)
			) u_sys (
				.ref_clk_in     (ref_clk_in),
				.rst_n_in       (rst_n_in),
				.line_write_in  (line_write_in[g]),
				.line_exec_in   (line_exec_in[g]),
				.on_th_in       (refill_on_threshold_r),
				.off_th_in      (full_off_threshold_r),
				.count_out      (cnt_all[g*CNT_W +: CNT_W]),
				.full_out       (full_all[g]),
				.write_seen_out (wseen_all[g])
			);
		end
	endgenerate

	// Panel select pins cross in through two flops
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pan_meta_r <= {SYS_W{1'b0}};
			pan_sync_r <= {SYS_W{1'b0}};
		end
		else
		begin
			pan_meta_r <= panel_system_select_in;
			pan_sync_r <= pan_meta_r;
		end
	end

	always @*
	begin
		if (panel_input_disable_r)
			sel_sys = host_sys_r; // R4
		else
			sel_sys = pan_sync_r; // R4
		sel_full = rbf_bit_of(full_all, sel_sys);
		// A write in this or the previous cycle forces the line low
		sel_wr = rbf_bit_of(line_write_in, sel_sys) |
			rbf_bit_of(wseen_all, sel_sys); // R7
		req_nxt = !sel_full && !sel_wr; // R1 R8
		// Rising request and entering full are the interrupt events
		int_set = 2'b00;
		int_set[`RBF_INT_RISE_BIT] = req_nxt && !req_prev_r; // R3
		int_set[`RBF_INT_FULL_BIT] = sel_full && !full_prev_r;
	end

	always @*
	begin
		rdata_nxt = {`RBF_DATA_W{1'b0}};
		case (reg_addr_in)
		`RBF_REG_CTRL:
			rdata_nxt[`RBF_CTRL_PANEL_DIS] = panel_input_disable_r;
		`RBF_REG_ON_TH:
			rdata_nxt = rbf_word_of(refill_on_threshold_r);
		`RBF_REG_OFF_TH:
			rdata_nxt = rbf_word_of(full_off_threshold_r);
		`RBF_REG_HOST_SYS:
			rdata_nxt[SYS_W-1:0] = host_sys_r;
		`RBF_REG_STATUS:
		begin
			// Full bit of the host-addressed system; request bit is the line itself
			rdata_nxt[`RBF_STAT_FULL_BIT] = rbf_bit_of(full_all, host_sys_r); // R2
			rdata_nxt[`RBF_STAT_REQ_BIT]  = buffer_request_line_out;
		end
		`RBF_REG_INT_STAT:
			rdata_nxt[1:0] = int_stat_r;
		`RBF_REG_INT_MASK:
			rdata_nxt[1:0] = int_mask_r;
		`RBF_REG_COUNT:
			rdata_nxt = rbf_word_of(rbf_count_of(cnt_all, host_sys_r));
		default:
			rdata_nxt = {`RBF_DATA_W{1'b0}};
		endcase
	end

	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			panel_input_disable_r   <= `RBF_CTRL_RST;
			refill_on_threshold_r   <= `RBF_ON_TH_RST;
			full_off_threshold_r    <= `RBF_OFF_TH_RST;
			host_sys_r              <= {SYS_W{1'b0}};
			int_stat_r              <= 2'b00;
			int_mask_r              <= 2'b00;
			req_prev_r              <= 1'b0;
			full_prev_r             <= 1'b0;
			buffer_request_line_out <= 1'b0;
			irq_out                 <= 1'b0;
			reg_rdata_out           <= {`RBF_DATA_W{1'b0}};
		end
		else
		begin
			if (reg_wr_in)
			begin
				case (reg_addr_in)
				`RBF_REG_CTRL:
					panel_input_disable_r <=
						reg_wdata_in[`RBF_CTRL_PANEL_DIS];
				`RBF_REG_ON_TH:
					refill_on_threshold_r <= reg_wdata_in[CNT_W-1:0];
				`RBF_REG_OFF_TH:
					full_off_threshold_r <= reg_wdata_in[CNT_W-1:0];
				`RBF_REG_HOST_SYS:
					host_sys_r <= reg_wdata_in[SYS_W-1:0];
				`RBF_REG_INT_MASK:
					int_mask_r <= reg_wdata_in[1:0];
				default:
					host_sys_r <= host_sys_r;
				endcase
			end
			// Set beats write-one-to-clear in the same cycle
			if (reg_wr_in && reg_addr_in == `RBF_REG_INT_STAT)
				int_stat_r <= (int_stat_r & ~reg_wdata_in[1:0]) | int_set;
			else
				int_stat_r <= int_stat_r | int_set;
			req_prev_r              <= req_nxt;
			full_prev_r             <= sel_full;
			buffer_request_line_out <= req_nxt; // R1 R6 R7
			irq_out <= |(int_stat_r & int_mask_r); // R3
			reg_rdata_out <= reg_rd_in ? rdata_nxt : {`RBF_DATA_W{1'b0}};
		end
	end
endmodule // rbf_flow_ctrl
`default_nettype wire

/* File: design/rbf_map.vh */
// Register map, field positions and reset values of the rotary buffer
// flow control block. Definitions only.
`ifndef RBF_MAP_VH
`define RBF_MAP_VH
`define RBF_ADDR_W        4
`define RBF_DATA_W        32
`define RBF_REG_CTRL      4'h0
`define RBF_REG_ON_TH     4'h1
`define RBF_REG_OFF_TH    4'h2
`define RBF_REG_HOST_SYS  4'h3
`define RBF_REG_STATUS    4'h4
`define RBF_REG_INT_STAT  4'h5
`define RBF_REG_INT_MASK  4'h6
`define RBF_REG_COUNT     4'h7
`define RBF_CTRL_PANEL_DIS 0
`define RBF_STAT_FULL_BIT 11
`define RBF_STAT_REQ_BIT  0
`define RBF_ON_TH_RST     24'h000005
`define RBF_OFF_TH_RST    24'h00000a
`define RBF_CTRL_RST      1'b0
`define RBF_INT_RISE_BIT  0
`define RBF_INT_FULL_BIT  1
`endif

/* File: design/rbf_sys_flow.v */
// One coordinate system: queued line count and hysteresis state.
// Assumes write and execute pulses come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module rbf_sys_flow #(
	parameter CNT_W = 24
) (
	// Clock and reset
	input  wire             ref_clk_in,
	input  wire             rst_n_in,
	// Line events
	input  wire             line_write_in,
	input  wire             line_exec_in,
	// Thresholds
	input  wire [CNT_W-1:0] on_th_in,
	input  wire [CNT_W-1:0] off_th_in,
	// State
	output reg  [CNT_W-1:0] count_out,
	output reg              full_out,
	output reg              write_seen_out
);
	reg [CNT_W-1:0] count_nxt;
	reg             full_nxt;

	always @*
	begin
		count_nxt = count_out;
		// Execution of an empty queue is ignored, so the count never wraps below zero
		if (line_write_in && !(line_exec_in && count_out != {CNT_W{1'b0}}))
			count_nxt = count_out + {{(CNT_W-1){1'b0}}, 1'b1}; // R9
		else if (line_exec_in && !line_write_in && count_out != {CNT_W{1'b0}})
			count_nxt = count_out - {{(CNT_W-1){1'b0}}, 1'b1}; // R9
		full_nxt = full_out;
		if (count_nxt >= off_th_in)
			full_nxt = 1'b1; // R8
		else if (count_nxt < on_th_in)
			full_nxt = 1'b0; // R1
		// Between the thresholds the previous state holds
	end // R6

	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			count_out      <= {CNT_W{1'b0}};
			full_out       <= 1'b0;
			write_seen_out <= 1'b0;
		end
		else
		begin
			count_out      <= count_nxt;
			full_out       <= full_nxt;
			write_seen_out <= line_write_in;
		end
	end
endmodule // rbf_sys_flow
`default_nettype wire

/* File: verif/rbf_flow_chk_asserts.sv */
// Port checker of rbf_flow_ctrl.
// Bound to each instance; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module rbf_flow_chk #(
	parameter NSYS = 8,
	parameter SYS_W = 3,
	parameter CNT_W = 24
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic [NSYS-1:0] line_write_in,
	input wire logic [NSYS-1:0] line_exec_in,
	input wire logic [SYS_W-1:0] panel_system_select_in,
	input wire logic buffer_request_line_out,
	input wire logic irq_out
);
	logic [1:0] mask_r;
	wire req = buffer_request_line_out;
	// Shadow of the mask, so irq can be judged without peeking inside
	always @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			mask_r <= 2'h0;
		else if (reg_wr_in && reg_addr_in == 4'h6)
			mask_r <= reg_wdata_in[1:0];
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_quiet;
		(line_write_in == '0) [*3];
	endsequence
	// Long enough for the write window and the panel sync to settle
	sequence s_idle;
		(line_write_in == '0 && line_exec_in == '0 && !reg_wr_in
			&& $stable(panel_system_select_in)) [*5];
	endsequence
	AST_RST_REQ: assert property ($rose(rst_n_in) ##0 s_quiet |-> req)
		else $error("no request after reset");
	AST_WR_DROP: assert property (line_write_in == '1 |=> (!req) [*2])
		else $error("request not dropped after write");
	AST_FULL_HOLD: assert property (s_idle ##0 !req |=> !req)
		else $error("request rose with no event");
	AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data without a read");
	AST_UNMAPPED: assert property (
		reg_rd_in && reg_addr_in[3] |=> reg_rdata_out == '0)
		else $error("unmapped read not zero");
	AST_MASK_RSV: assert property (
		reg_rd_in && reg_addr_in == 4'h6 |=> reg_rdata_out[31:2] == '0)
		else $error("mask spare bits set");
	AST_IRQ_OFF: assert property ((mask_r == 2'h0) [*2] |-> !irq_out)
		else $error("irq with mask clear");
	AST_IRQ_RISE: assert property (
		mask_r[0] && $rose(req) |-> ##[1:3] irq_out)
		else $error("irq missing after request rise");
endmodule // rbf_flow_chk
bind rbf_flow_ctrl rbf_flow_chk #(
	.NSYS  (NSYS),
	.SYS_W (SYS_W),
	.CNT_W (CNT_W)
) u_chk (
	.ref_clk_in              (ref_clk_in),
	.rst_n_in                (rst_n_in),
	.reg_addr_in             (reg_addr_in),
	.reg_wdata_in            (reg_wdata_in),
	.reg_wr_in               (reg_wr_in),
	.reg_rd_in               (reg_rd_in),
	.reg_rdata_out           (reg_rdata_out),
	.line_write_in           (line_write_in),
	.line_exec_in            (line_exec_in),
	.panel_system_select_in  (panel_system_select_in),
	.buffer_request_line_out (buffer_request_line_out),
	.irq_out                 (irq_out)
);
`default_nettype wire

/* File: verif/rbf_host_intc.sv */
// Host interrupt controller model: counts rising edges of irq.
// Assumes irq is synchronous to ref_clk_in; count survives resets.
`timescale 1ns/1ns
`default_nettype none
module rbf_host_intc (
	// Clock and interrupt
	input wire logic ref_clk_in,
	input wire logic irq_in,
	// Interrupts taken
	output var logic [7:0] hits_out
);
	logic prev_r = 1'b0;
	initial hits_out = 8'h00;
	always @(posedge ref_clk_in)
	begin
		prev_r <= irq_in;
		if (irq_in && !prev_r)
			hits_out <= hits_out + 8'h01;
	end
endmodule // rbf_host_intc
`default_nettype wire

/* File: verif/rbf_flow_tb.sv */
// Self-checking bench of rbf_flow_ctrl with a host interrupt model.
// Assumes default NSYS=8; thresholds reset to 5 and 10.
`timescale 1ns/1ns
`default_nettype none
module rotary_buffer_request_flow_control_test;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic [7:0] line_write_in = 8'h00;
	logic [7:0] line_exec_in = 8'h00;
	logic [2:0] panel_system_select_in = 3'h5;
	logic buffer_request_line_out;
	logic irq_out;
	logic [7:0] hits;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	// Address beside the value it must read back after reset
	logic [35:0] rows [9] = '{36'h0, 36'h100000005, 36'h20000000a,
		36'h300000000, 36'h400000001, 36'h600000000, 36'h700000000,
		36'h800000000, 36'hf00000000};
	rbf_flow_ctrl u_dut (
		.ref_clk_in              (ref_clk_in),
		.rst_n_in                (rst_n_in),
		.reg_addr_in             (reg_addr_in),
		.reg_wdata_in            (reg_wdata_in),
		.reg_wr_in               (reg_wr_in),
		.reg_rd_in               (reg_rd_in),
		.reg_rdata_out           (reg_rdata_out),
		.line_write_in           (line_write_in),
		.line_exec_in            (line_exec_in),
		.panel_system_select_in  (panel_system_select_in),
		.buffer_request_line_out (buffer_request_line_out),
		.irq_out                 (irq_out)
	);
	rbf_host_intc u_host (
		.ref_clk_in (ref_clk_in),
		.irq_in     (irq_out),
		.hits_out   (hits)
	);
	initial
		forever #20 ref_clk_in = ~ref_clk_in;
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 1000)
		begin
			n_errors++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	task automatic line(input logic w, input logic [7:0] m, input int n);
		repeat (n)
		begin
			@(posedge ref_clk_in);
			if (w)
				line_write_in <= m;
			else
				line_exec_in <= m;
			@(posedge ref_clk_in);
			line_write_in <= 8'h00;
			line_exec_in <= 8'h00;
		end
	endtask
	// Bit 1 is irq, bit 0 the request line
	task automatic look(input logic [1:0] exp);
		repeat (4) @(posedge ref_clk_in);
		#1 chk({30'h0, irq_out, buffer_request_line_out}, {30'h0, exp});
	endtask
	task automatic do_reset;
		@(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
	endtask
	task automatic table_pass;
		for (int i = 0; i < 9; i++)
			rd(rows[i][35:32], rows[i][31:0]);
		$display("register table done");
	endtask
	initial
	begin
		do_reset;
		table_pass;
		wr(4'h1, 32'h6);
		wr(4'h3, 32'h2);
		wr(4'h0, 32'h1);
		wr(4'h5, 32'h3);
		wr(4'h6, 32'h3);
		look(2'b01);
		line(1'b1, 8'hff, 1);
		line(1'b1, 8'h04, 8);
		look(2'b11);
		line(1'b1, 8'h04, 1);
		look(2'b10);
		rd(4'h5, 32'h3);
		rd(4'h4, 32'h800);
		rd(4'h7, 32'ha);
		$display("fill done");
		wr(4'h5, 32'h3);
		look(2'b00);
		wr(4'h0, 32'h0);
		look(2'b11);
		// Panel pins move to the full system while the panel is enabled
		@(posedge ref_clk_in);
		panel_system_select_in <= 3'h2;
		look(2'b10);
		wr(4'h0, 32'h1);
		look(2'b10);
		wr(4'h5, 32'h3);
		look(2'b00);
		$display("panel select done");
		line(1'b0, 8'h04, 4);
		look(2'b00);
		line(1'b0, 8'h04, 1);
		look(2'b11);
		rd(4'h4, 32'h1);
		rd(4'h7, 32'h5);
		chk({24'h0, hits}, 32'h3);
		// Write and execute in one cycle leave the count unchanged
		@(posedge ref_clk_in);
		line_write_in <= 8'h04;
		line_exec_in <= 8'h04;
		@(posedge ref_clk_in);
		line_write_in <= 8'h00;
		line_exec_in <= 8'h00;
		rd(4'h7, 32'h5);
		// Second execute finds an empty queue and must not wrap
		line(1'b0, 8'h80, 2);
		wr(4'h3, 32'h7);
		rd(4'h7, 32'h0);
		$display("drain done");
		do_reset;
		table_pass;
		report_and_stop;
	end
endmodule // rotary_buffer_request_flow_control_test
`default_nettype wire
